// ===== common/eeprom_map.svh
// Constants for the two-wire EEPROM write slave: offsets, field values, timing.
// Assumes the includer compiles it once per unit; guarded for repeat inclusion.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// Device type code in the top nibble of the address byte
`define EE_DEV_TYPE      4'hA
// Bit counter value during the acknowledge clock
`define EE_ACK_SLOT      4'h8
// Bit counter value at the last data bit of a byte
`define EE_LAST_BIT      4'h7
// Page layout: 16 pages of 16 bytes, 8-bit word address
`define EE_PAGE_BYTES    16
`define EE_MEM_BYTES     256
// Self-timed programming cycle, longest time, in ms
`define EE_WRITE_CYCLE_MS 5
// System clock rate in Hz
`define EE_MCLK_HZ       200000000
// Cycles of mclk in one programming cycle (rounded down)
`define EE_WRITE_CYCLE_CYCLES (`EE_WRITE_CYCLE_MS * (`EE_MCLK_HZ / 1000))

`endif

// ===== common/eeprom_pkg.sv
// Types shared by the two-wire EEPROM write slave.
// Assumes the map header is compiled alongside.
package eeprom_pkg;

  // Link-side byte phase, Gray coded along the usual path
  typedef enum logic [2:0] {
    LINK_IDLE  = 3'b000,
    LINK_DEV   = 3'b001,
    LINK_WORD  = 3'b011,
    LINK_DATA  = 3'b010,
    LINK_RWAIT = 3'b110
  } link_state_e;

  typedef logic [7:0] byte_t;

endpackage

// ===== core/two_wire_eeprom_write_slave.sv
// Target side of a 256-byte two-wire serial EEPROM: addressing, byte and page
// writes, acknowledge polling and a self-timed programming cycle.
// Assumes an external pull-up on the data wire and SCL from the bus controller.
//
// How it works
// (R01) Sample on SCL rise, drive on fall
// (R02) Data line only pulled low or released
// (R03) Floating chip-select pins read as low
// (R04) Sixteen pages of sixteen bytes, 8-bit address
// (R05) Controller changes data only while SCL low
// (R06) Data fall with SCL high is START
// (R07) Data rise with SCL high is STOP
// (R08) Read STOP idles; write STOP programs first
// (R09) Acknowledge accepted byte on ninth clock
// (R10) Address match: 1010 plus chip-select levels
// (R11) Mismatch: no acknowledge, wait for START
// (R12) Eighth address bit selects read or write
// (R13) Byte write acknowledged at 9, 18, 27
// (R14) Write STOP starts 5 ms self-timed program
// (R15) Page write acknowledges each extra byte
// (R16) Only low four column bits increment
// (R17) Over 16 bytes overwrite wrapped columns
// (R18) Page write from any column, partial allowed
// (R19) No address acknowledge while programming
// (R20) Standby after power-up
// (R21) Address counter holds last address plus one
// (R22) START mid-transfer restarts address reception
`timescale 1ns/1ps
`include "eeprom_map.svh"

module two_wire_eeprom_write_slave
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLE_CYCLES = `EE_WRITE_CYCLE_CYCLES
) (
  // System clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Two-wire bus
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Strapped chip-select pins
  input  wire logic [2:0] chip_select_pins,
  // Status
  output logic            standby,
  output logic            programming,
  output logic [7:0]      word_addr,
  // Memory inspection port
  input  wire logic [7:0] peek_addr,
  output byte_t           peek_data
);

  // ------------------------------------------------------------
  // System-side pin synchronisers and bus condition detect
  // ------------------------------------------------------------
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;
  logic start_det;
  logic stop_det;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign start_det = scl_s2 && scl_d && sda_d && !sda_s2; // R06
  assign stop_det  = scl_s2 && scl_d && !sda_d && sda_s2; // R07

  // ------------------------------------------------------------
  // Frame tracking and link-side restart
  // ------------------------------------------------------------
  logic frame_active;
  logic frame_restart;
  logic busy;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_active <= 1'b0;
    end else if (start_det) begin
      frame_active <= 1'b1;
    end else if (stop_det) begin
      frame_active <= 1'b0;
    end
  end

  // Holds link logic in reset from START or STOP until SCL next goes low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_restart <= 1'b1;
    end else if (start_det || stop_det) begin
      frame_restart <= 1'b1; // R22
    end else if (!scl_s2) begin
      frame_restart <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Link domain: synchronisers clocked by SCL
  // ------------------------------------------------------------
  logic       link_rst;
  logic [2:0] cs_s1;
  logic [2:0] cs_s2;
  logic       frame_s1;
  logic       frame_s2;
  logic       busy_s1;
  logic       busy_s2;

  assign link_rst = rst | frame_restart;

  // Unconnected pins are pulled low at the pad; sampled here as-is
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      cs_s1    <= 3'h0;
      cs_s2    <= 3'h0;
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      busy_s1  <= 1'b0;
      busy_s2  <= 1'b0;
    end else begin
      cs_s1    <= chip_select_pins; // R03
      cs_s2    <= cs_s1;
      frame_s1 <= frame_active;
      frame_s2 <= frame_s1;
      busy_s1  <= busy;
      busy_s2  <= busy_s1;
    end
  end

  // ------------------------------------------------------------
  // Link domain: byte receiver and acknowledge decision
  // ------------------------------------------------------------
  link_state_e state;
  logic [3:0]  bit_cnt;
  logic [6:0]  shift;
  logic        ack;
  logic        read_mode;
  byte_t       full_byte;
  logic        addr_match;

  assign full_byte  = {shift, sda_in};
  assign addr_match = (full_byte[7:4] == `EE_DEV_TYPE)
                   && (full_byte[3:1] == cs_s2)
                   && frame_s2
                   && !busy_s2;

  // SDA is stable while SCL high, so it is taken directly on the rising edge
  always_ff @(posedge scl or posedge link_rst) begin
    if (link_rst) begin
      state     <= LINK_DEV; // R22
      bit_cnt   <= 4'h0;
      shift     <= 7'h00;
      ack       <= 1'b0;
      read_mode <= 1'b0;
    end else if (bit_cnt == `EE_ACK_SLOT) begin
      bit_cnt <= 4'h0;
      if (!ack) begin
        state <= LINK_IDLE; // R11
      end else begin
        case (state)
          LINK_DEV:  state <= read_mode ? LINK_RWAIT : LINK_WORD; // R12
          LINK_WORD: state <= LINK_DATA; // R13
          LINK_DATA: state <= LINK_DATA; // R15
          default:   state <= LINK_IDLE;
        endcase
      end
    end else if (state != LINK_IDLE) begin
      shift   <= full_byte[6:0]; // R01
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == `EE_LAST_BIT) begin
        case (state)
          LINK_DEV: begin
            ack       <= addr_match; // R10 R19
            read_mode <= full_byte[0]; // R12
          end
          LINK_WORD: ack <= 1'b1; // R09 R13
          LINK_DATA: ack <= 1'b1; // R09 R15
          default:   ack <= 1'b0;
        endcase
      end
    end
  end

  // Received word-address and data bytes handed to the system side
  byte_t rx_byte;
  logic  rx_is_data;
  logic  rx_tgl;

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      rx_byte    <= 8'h00;
      rx_is_data <= 1'b0;
      rx_tgl     <= 1'b0;
    end else if (bit_cnt == `EE_LAST_BIT
                 && (state == LINK_WORD || state == LINK_DATA)) begin
      rx_byte    <= full_byte;
      rx_is_data <= (state == LINK_DATA);
      rx_tgl     <= ~rx_tgl;
    end
  end

  // ------------------------------------------------------------
  // Link domain: open-drain driver on the falling edge
  // ------------------------------------------------------------
  always_ff @(negedge scl or posedge link_rst) begin
    if (link_rst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0; // R02
      sda_oe  <= (bit_cnt == `EE_ACK_SLOT) && ack; // R01 R09
    end
  end

  // ------------------------------------------------------------
  // System side: byte event crossing
  // ------------------------------------------------------------
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic rx_evt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
      rx_s3 <= 1'b0;
    end else begin
      rx_s1 <= rx_tgl;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  // Byte value is held stable for nine SCL periods after the toggle
  assign rx_evt = rx_s2 ^ rx_s3;

  // ------------------------------------------------------------
  // System side: address counter and page buffer
  // ------------------------------------------------------------
  logic [3:0]                 row;
  logic [3:0]                 col;
  logic [`EE_PAGE_BYTES-1:0]  loaded;
  byte_t                      page_buf [`EE_PAGE_BYTES];
  logic                       commit;

  assign commit = stop_det && !busy && (loaded != '0); // R08 R14

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      row    <= 4'h0;
      col    <= 4'h0;
      loaded <= '0;
    end else if (start_det || commit) begin
      loaded <= '0; // R22
    end else if (rx_evt && !busy) begin
      if (!rx_is_data) begin
        row    <= rx_byte[7:4]; // R04 R18
        col    <= rx_byte[3:0];
        loaded <= '0;
      end else begin
        col         <= col + 4'h1; // R16 R21
        loaded[col] <= 1'b1; // R17
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rx_evt && !busy && rx_is_data) begin
      page_buf[col] <= rx_byte; // R17
    end
  end

  // ------------------------------------------------------------
  // System side: memory array and programming
  // ------------------------------------------------------------
  byte_t mem [`EE_MEM_BYTES];

  always_ff @(posedge mclk) begin
    if (commit) begin
      for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
        if (loaded[i]) begin
          mem[{row, 4'(i)}] <= page_buf[i]; // R04 R18
        end
      end
    end
    peek_data <= mem[peek_addr];
  end

  // ------------------------------------------------------------
  // System side: self-timed programming cycle
  // ------------------------------------------------------------
  logic [19:0] wc_count;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy     <= 1'b0; // R20
      wc_count <= 20'h00000;
    end else if (commit) begin
      busy     <= 1'b1; // R14
      wc_count <= 20'(WRITE_CYCLE_CYCLES);
    end else if (busy) begin
      wc_count <= wc_count - 20'h00001;
      if (wc_count == 20'h00001) begin
        busy <= 1'b0; // R08 R14
      end
    end
  end

  // ------------------------------------------------------------
  // Status outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      standby     <= 1'b1; // R20
      programming <= 1'b0;
      word_addr   <= 8'h00;
    end else begin
      standby     <= !busy && !frame_active && !commit; // R08
      programming <= busy;
      word_addr   <= {row, col}; // R21
    end
  end

endmodule // two_wire_eeprom_write_slave

// ===== tb/eeprom_props.sv
// Checker for the two-wire EEPROM write slave, bound to its top ports.
// Assumes a single mclk domain with asynchronous reset rst.
`timescale 1ns/1ps
module eeprom_props
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLE_CYCLES = 200
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Bus and status
  input wire logic       scl,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       standby,
  input wire logic       programming,
  input wire logic [7:0] word_addr
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  int busy_len;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) busy_len <= 0;
    else busy_len <= programming ? busy_len + 1 : 0;
  end
  a_release_only: assert property (!sda_out) else $error("data line driven high");
  a_ack_on_low: assert property ($changed(sda_oe) |-> !scl) else $error("ack moved with scl high");
  a_boot_standby: assert property ($fell(rst) |-> standby && !programming) else $error("not idle");
  a_busy_not_idle: assert property (programming |-> !standby) else $error("idle while busy");
  a_cycle_bound: assert property (busy_len <= WRITE_CYCLE_CYCLES + 4) else $error("cycle too long");
  a_back_to_idle: assert property ($fell(programming) |-> ##[0:2] standby) else $error("no idle");
  a_no_poll_ack: assert property (programming |-> !sda_oe) else $error("ack while busy");
  a_addr_frozen: assert property (programming && $past(programming) |-> $stable(word_addr))
    else $error("address moved while busy");
  cover property ($rose(programming));
  cover property ($rose(sda_oe));
  cover property ($fell(programming));
endmodule // eeprom_props

bind two_wire_eeprom_write_slave eeprom_props #(.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)) props (
  .mclk(mclk), .rst(rst), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
  .standby(standby), .programming(programming), .word_addr(word_addr));

// ===== tb/bus_controller.sv
// Bus controller model: drives scl and pulls the data wire low.
// Assumes a pull-up on the data wire; scl period 30 ns, still when idle.
`timescale 1ns/1ps
module bus_controller (
  // Bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    // Odd offset keeps bus edges clear of mclk edges
    #1.3 sda_low = 1'b0;
    #10 scl = 1'b1;
    #30 sda_low = 1'b1;
    #30 scl = 1'b0;
    // Long first low phase lets the target leave its restart hold
    #15;
  endtask
  task automatic stop();
    #5 sda_low = 1'b1;
    #10 scl = 1'b1;
    #30 sda_low = 1'b0;
    #30;
  endtask
  task automatic wbits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      #5 sda_low = !v[i];
      #10 scl = 1'b1;
      #15 scl = 1'b0;
    end
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    wbits(v, 8);
    #5 sda_low = 1'b0;
    #10 scl = 1'b1;
    #7 ack = !sda;
    #8 scl = 1'b0;
  endtask
endmodule // bus_controller

// ===== tb/testbench.sv
// Self-checking bench for the two-wire EEPROM write slave.
// Assumes the bus controller model and the bound checker.
`timescale 1ns/1ps
module testbench
  import eeprom_pkg::*;
;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam int WCC = 200;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] cs = 3'h0;
  logic [7:0] peek_addr = 8'h00;
  logic [7:0] model [256];
  logic       ack;
  int         failures = 0;
  int         checks = 0;
  wire        scl, ctl_low, sda_oe, sda_out, standby, programming;
  wire  [7:0] word_addr;
  byte_t      peek_data;
  wire        sda = !(ctl_low || sda_oe);
  always #2.5 mclk = ~mclk;
  bus_controller ctl (.scl(scl), .sda_low(ctl_low), .sda(sda));
  two_wire_eeprom_write_slave #(.WRITE_CYCLE_CYCLES(WCC)) dut (.mclk(mclk), .rst(rst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(cs), .standby(standby),
    .programming(programming), .word_addr(word_addr), .peek_addr(peek_addr), .peek_data(peek_data));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] dev(input logic rw);
    return {4'hA, cs, rw};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic frame(input logic [7:0] v, input logic e);
    ctl.start();
    ctl.wbyte(v, ack);
    check("addr ack", ack, e);
    ctl.stop();
  endtask
  task automatic write(input logic [7:0] a, input int n, input int restart);
    logic [7:0] d;
    if (restart != 0) begin
      ctl.start();
      ctl.wbits(dev(1'b0), 5);
    end
    ctl.start();
    ctl.wbyte(dev(1'b0), ack);
    check("ack 9", ack, 1'b1);
    ctl.wbyte(a, ack);
    check("ack 18", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ctl.wbyte(d, ack);
      check("data ack", ack, 1'b1);
      model[{a[7:4], a[3:0] + i[3:0]}] = d;
    end
    ctl.stop();
    repeat (10) @(posedge mclk);
    check("busy", programming, n > 0);
    if (n > 0) begin
      frame(dev(1'b0), 1'b0);
      for (int w = 0; w < WCC + 50 && programming !== 1'b0; w++) @(posedge mclk);
      repeat (2) @(posedge mclk);
      check("standby", standby, 1'b1);
      check("word_addr", word_addr, {a[7:4], a[3:0] + n[3:0]});
      frame(dev(1'b0), 1'b1);
      for (int c = 0; c < 16; c++) begin
        @(posedge mclk);
        peek_addr <= {a[7:4], c[3:0]};
        repeat (2) @(posedge mclk);
        #1 if (model[peek_addr] !== 8'hXX) check("mem", peek_data, model[peek_addr]);
      end
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1733));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("standby", standby, 1'b1);
    check("word_addr", word_addr, 8'h00);
    write(8'h3E, 18, 0);
    write(8'h75, 0, 0);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      cs <= 3'($urandom);
      @(posedge mclk);
      write(8'($urandom), 1 + $urandom % 6, k % 2);
    end
    frame({4'hA, ~cs, 1'b0}, 1'b0);
    frame({4'h5, cs, 1'b0}, 1'b0);
    frame(dev(1'b1), 1'b1);
    repeat (10) @(posedge mclk);
    check("busy", programming, 1'b0);
    conclude();
  end
  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule // testbench
